// file: uuer_pkg.sv
/*
 * Shared constants for the upstream endpoint register block: register
 * indices, field positions, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with one word per register.
 */
`default_nettype none
package uuer_pkg;
    localparam int ADDR_W = 12;
    localparam int WORD_W = ADDR_W - 2;
    localparam int EP_NUM = 4;
    localparam int EP_W = 2;
    localparam int PTR_W = 3;
    localparam int BUF_AW = EP_W + 1 + PTR_W;
    localparam int BUF_BYTES = 64;

    // Register indices; the byte address is four times the index.
    localparam logic [WORD_W-1:0] REG_MAIN_STATUS = 10'h0a0;
    localparam logic [WORD_W-1:0] REG_MAIN_CONTROL = 10'h0a1;
    localparam logic [WORD_W-1:0] REG_FUNCTION_ADDRESS = 10'h0a2;
    localparam logic [WORD_W-1:0] REG_ENDPOINT_ENABLE = 10'h0a3;
    localparam logic [WORD_W-1:0] REG_ENDPOINT_CONFIG = 10'h0a6;
    localparam logic [WORD_W-1:0] REG_BUFFER_SELECT = 10'h0a8;
    localparam logic [WORD_W-1:0] REG_HANDSHAKE_STATUS = 10'h0aa;
    localparam logic [WORD_W-1:0] REG_BUFFER_DATA_PORT = 10'h0ab;
    localparam logic [WORD_W-1:0] REG_BUFFER_COUNT_LOW = 10'h0ac;
    localparam logic [WORD_W-1:0] REG_PROCESSOR_COUNT_LOW = 10'h0ae;

    // Main status and main control fields.
    localparam int MS_SOF = 0;
    localparam int MS_RXF = 1;
    localparam int MS_TXE = 2;
    localparam int MS_IDLE = 3;
    localparam int MS_BRST = 4;
    localparam int MS_RSM = 7;
    localparam int MC_CLK_STOP = 4;
    localparam int MC_RSM_IE = 5;
    localparam int MC_RSM_DRV = 6;
    localparam int MC_SUSPEND = 7;
    localparam logic [7:0] MC_RESET = 8'h00;

    // Endpoint configuration fields.
    localparam int CF_DEV_LSB = 0;
    localparam int CF_DEV1_EN = 4;
    localparam int CF_DEV2_EN = 5;
    localparam int CF_BUF_DEV0 = 6;
    localparam logic [7:0] CF_MASK = 8'h73;

    // Buffer select fields.
    localparam int BS_DIR = 2;
    localparam int BS_RXCLR_N = 3;
    localparam int BS_WBUSY = 2;
    localparam int BS_RBUSY = 3;

    // Handshake status fields.
    localparam int HS_ACK_TX = 0;
    localparam int HS_ERR = 1;
    localparam int HS_ACK_RX = 2;
    localparam int HS_STALL = 2;
    localparam int HS_SETUP = 3;
    localparam int HS_TOGGLE = 4;
    localparam int HS_RXF = 5;
    localparam int HS_TXE = 6;
    localparam int HS_DIR = 7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: uuer_regs.sv
/*
 * Register file of the upstream serial interface engine: main status and
 * control, function address, endpoint enables and configuration, the
 * shared endpoint buffer with its data and count ports, and the handshake
 * status per endpoint, all behind an AXI4-Lite slave.
 * Assumes the engine's event inputs are single-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module uuer_regs (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [uuer_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [uuer_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sie_sof,
    input wire logic sie_bus_idle,
    input wire logic sie_bus_reset,
    input wire logic sie_resume,
    input wire logic [uuer_pkg::EP_W-1:0] sie_ep,
    input wire logic sie_rx_done,
    input wire logic sie_rx_setup,
    input wire logic [7:0] sie_rx_count,
    input wire logic sie_tx_done,
    input wire logic sie_error,
    input wire logic sie_buf_wr,
    input wire logic [uuer_pkg::BUF_AW-1:0] sie_buf_addr,
    input wire logic [7:0] sie_buf_wdata,
    output logic [7:0] sie_buf_rdata,
    output logic [7:0] sie_tx_count,
    output logic [6:0] function_address,
    output logic [uuer_pkg::EP_NUM-1:0] endpoint_enable,
    output logic [uuer_pkg::EP_NUM-1:0] endpoint_stall,
    output logic [uuer_pkg::EP_NUM-1:0] endpoint_toggle,
    output logic [uuer_pkg::EP_NUM-1:0] transmit_loaded_flag,
    output logic [1:0] config_device_address,
    output logic config_device1_enable,
    output logic config_device2_enable,
    output logic buffer_to_device0,
    output logic clock_stop_request,
    output logic drive_resume,
    output logic suspend_in,
    output logic usb_irq
);
    import uuer_pkg::*;

    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic [WORD_W-1:0] aw_idx_ff, rd_idx_ff;
    logic [7:0] wbyte_ff;
    logic wstb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [7:0] rdata_ff;
    logic wr_go, ar_go;
    logic [WORD_W-1:0] ar_idx;

    logic [7:0] ctrl_ff, cfg_ff;
    logic st_sof_ff, st_rxf_ff, st_txe_ff, st_idle_ff, st_rsm_ff;
    logic [6:0] func_addr_ff;
    logic [EP_NUM-1:1] ep_en_ff;
    logic [EP_W-1:0] sel_ep_ff;
    logic sel_dir_ff, wbusy_ff, rbusy_ff, irq_ff;
    logic [PTR_W-1:0] ptr_ff;
    logic [EP_NUM-1:0] stall_ff, tog_ff, ack_tx_ff, err_ff, ack_rx_ff;
    logic [EP_NUM-1:0] setup_ff, rxf_ff, txl_ff, dir_ff;
    logic [7:0] rx_cnt_ff [EP_NUM];
    logic [7:0] tx_cnt_ff [EP_NUM];
    logic [7:0] buf_mem [BUF_BYTES];
    logic [7:0] sie_rdata_ff, sie_txc_ff;
    logic [BUF_AW-1:0] cpu_addr;

    logic w_ctrl, w_func, w_epen, w_cfg, w_sel, w_hs, w_data, w_cnt;
    logic w_hit, r_hit, r_data;
    logic [7:0] rd_val;

    // A read is held off while a write completes so that both channels
    // never move the byte pointer in the same cycle.
    assign s_axi_awready = clk_en & ~aw_got_ff & ~bvalid_ff;
    assign s_axi_wready = clk_en & ~w_got_ff & ~bvalid_ff;
    assign wr_go = clk_en & aw_got_ff & w_got_ff & ~bvalid_ff;
    assign s_axi_arready = clk_en & ~rvalid_ff & ~wr_go;
    assign ar_go = s_axi_arvalid & s_axi_arready;
    assign ar_idx = s_axi_araddr[ADDR_W-1:2];
    assign cpu_addr = {sel_ep_ff, sel_dir_ff, ptr_ff};

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            aw_idx_ff <= '0;
            wbyte_ff <= 8'h00;
            wstb_ff <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                aw_idx_ff <= s_axi_awaddr[ADDR_W-1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wbyte_ff <= s_axi_wdata[7:0];
                wstb_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= w_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        w_ctrl = 1'b0;
        w_func = 1'b0;
        w_epen = 1'b0;
        w_cfg = 1'b0;
        w_sel = 1'b0;
        w_hs = 1'b0;
        w_data = 1'b0;
        w_cnt = 1'b0;
        w_hit = 1'b1;
        if (aw_idx_ff == REG_MAIN_STATUS) begin
        end else if (aw_idx_ff == REG_MAIN_CONTROL) begin
            w_ctrl = 1'b1;
        end else if (aw_idx_ff == REG_FUNCTION_ADDRESS) begin
            w_func = 1'b1;
        end else if (aw_idx_ff == REG_ENDPOINT_ENABLE) begin
            w_epen = 1'b1;
        end else if (aw_idx_ff == REG_ENDPOINT_CONFIG) begin
            w_cfg = 1'b1;
        end else if (aw_idx_ff == REG_BUFFER_SELECT) begin
            w_sel = 1'b1;
        end else if (aw_idx_ff == REG_HANDSHAKE_STATUS) begin
            w_hs = 1'b1;
        end else if (aw_idx_ff == REG_BUFFER_DATA_PORT) begin
            w_data = 1'b1;
        end else if (aw_idx_ff == REG_BUFFER_COUNT_LOW ||
                     aw_idx_ff == REG_PROCESSOR_COUNT_LOW) begin
            w_cnt = 1'b1;
        end else begin
            w_hit = 1'b0;
        end
    end

    // Register side effects fire only on an accepted write with lane 0 on.
    logic wr_en;
    assign wr_en = wr_go & wstb_ff;

    always_comb begin
        rd_val = 8'h00;
        r_hit = 1'b1;
        r_data = 1'b0;
        if (ar_idx == REG_MAIN_STATUS) begin
            rd_val[MS_SOF] = st_sof_ff;
            rd_val[MS_RXF] = st_rxf_ff;
            rd_val[MS_TXE] = st_txe_ff;
            rd_val[MS_IDLE] = st_idle_ff;
            rd_val[MS_BRST] = sie_bus_reset;
            rd_val[MS_RSM] = st_rsm_ff;
        end else if (ar_idx == REG_MAIN_CONTROL) begin
            rd_val = ctrl_ff;
        end else if (ar_idx == REG_FUNCTION_ADDRESS) begin
            rd_val = {1'b0, func_addr_ff};
        end else if (ar_idx == REG_ENDPOINT_ENABLE) begin
            rd_val = {4'h0, ep_en_ff, 1'b1};
        end else if (ar_idx == REG_ENDPOINT_CONFIG) begin
            rd_val = 8'h00;
        end else if (ar_idx == REG_BUFFER_SELECT) begin
            rd_val[EP_W-1:0] = sel_ep_ff;
            rd_val[BS_WBUSY] = wbusy_ff;
            rd_val[BS_RBUSY] = rbusy_ff;
        end else if (ar_idx == REG_HANDSHAKE_STATUS) begin
            rd_val[HS_ACK_TX] = ack_tx_ff[sel_ep_ff];
            rd_val[HS_ERR] = err_ff[sel_ep_ff];
            rd_val[HS_ACK_RX] = ack_rx_ff[sel_ep_ff];
            rd_val[HS_SETUP] = setup_ff[sel_ep_ff];
            rd_val[HS_TOGGLE] = tog_ff[sel_ep_ff];
            rd_val[HS_RXF] = rxf_ff[sel_ep_ff];
            rd_val[HS_TXE] = ~txl_ff[sel_ep_ff];
            rd_val[HS_DIR] = dir_ff[sel_ep_ff];
        end else if (ar_idx == REG_BUFFER_DATA_PORT) begin
            rd_val = buf_mem[cpu_addr];
            r_data = 1'b1;
        end else if (ar_idx == REG_BUFFER_COUNT_LOW ||
                     ar_idx == REG_PROCESSOR_COUNT_LOW) begin
            rd_val = rx_cnt_ff[sel_ep_ff];
        end else begin
            r_hit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 8'h00;
            rresp_ff <= RESP_OKAY;
            rd_idx_ff <= '0;
        end else if (clk_en) begin
            if (ar_go) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_val;
                rresp_ff <= r_hit ? RESP_OKAY : RESP_SLVERR;
                rd_idx_ff <= ar_idx;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Sticky main status flags; a hardware event wins over a clear.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_ff <= MC_RESET;
            st_sof_ff <= 1'b0;
            st_rxf_ff <= 1'b0;
            st_txe_ff <= 1'b0;
            st_idle_ff <= 1'b0;
            st_rsm_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            if (w_ctrl && wr_en) begin
                ctrl_ff <= wbyte_ff;
                if (!wbyte_ff[MS_SOF]) st_sof_ff <= 1'b0;
                if (!wbyte_ff[MS_RXF]) st_rxf_ff <= 1'b0;
                if (!wbyte_ff[MS_TXE]) st_txe_ff <= 1'b0;
                if (!wbyte_ff[MS_IDLE]) st_idle_ff <= 1'b0;
                if (!wbyte_ff[MC_RSM_IE]) st_rsm_ff <= 1'b0;
            end
            if (sie_sof && ctrl_ff[MS_SOF]) st_sof_ff <= 1'b1;
            if (sie_rx_done && ctrl_ff[MS_RXF]) st_rxf_ff <= 1'b1;
            if (sie_tx_done && ctrl_ff[MS_TXE]) st_txe_ff <= 1'b1;
            if (sie_bus_idle) st_idle_ff <= 1'b1;
            if (sie_resume && ctrl_ff[MC_RSM_IE]) st_rsm_ff <= 1'b1;
            irq_ff <= st_sof_ff | st_rxf_ff | st_txe_ff | st_rsm_ff;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            func_addr_ff <= 7'h00;
            ep_en_ff <= '0;
            cfg_ff <= 8'h00;
        end else if (clk_en && wr_en) begin
            if (w_func) func_addr_ff <= wbyte_ff[6:0];
            if (w_epen) ep_en_ff <= wbyte_ff[EP_NUM-1:1];
            if (w_cfg) cfg_ff <= wbyte_ff & CF_MASK;
        end
    end

    // Buffer selection, byte pointer and the access-in-progress flags.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sel_ep_ff <= '0;
            sel_dir_ff <= 1'b0;
            ptr_ff <= '0;
            wbusy_ff <= 1'b0;
            rbusy_ff <= 1'b0;
        end else if (clk_en) begin
            wbusy_ff <= w_data & wr_en;
            rbusy_ff <= ar_go & r_data;
            if (w_sel && wr_en) begin
                sel_ep_ff <= wbyte_ff[EP_W-1:0];
                sel_dir_ff <= wbyte_ff[BS_DIR];
                ptr_ff <= '0;
            end else if ((w_data && wr_en) || (ar_go && r_data)) begin
                ptr_ff <= ptr_ff + 3'h1;
            end
        end
    end

    // Per-endpoint handshake state. Engine events are applied first so a
    // software set of the same flag in that cycle still lands.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stall_ff <= '0;
            tog_ff <= '0;
            ack_tx_ff <= '0;
            err_ff <= '0;
            ack_rx_ff <= '0;
            setup_ff <= '0;
            rxf_ff <= '0;
            txl_ff <= '0;
            dir_ff <= '0;
            for (int i = 0; i < EP_NUM; i++) begin
                rx_cnt_ff[i] <= 8'h00;
                tx_cnt_ff[i] <= 8'h00;
            end
        end else if (clk_en) begin
            if (sie_rx_done) begin
                rxf_ff[sie_ep] <= 1'b1;
                ack_rx_ff[sie_ep] <= 1'b1;
                err_ff[sie_ep] <= 1'b0;
                setup_ff[sie_ep] <= sie_rx_setup;
                dir_ff[sie_ep] <= 1'b0;
                tog_ff[sie_ep] <= ~tog_ff[sie_ep];
                rx_cnt_ff[sie_ep] <= sie_rx_count;
            end else if (sie_tx_done) begin
                txl_ff[sie_ep] <= 1'b0;
                ack_tx_ff[sie_ep] <= 1'b1;
                err_ff[sie_ep] <= 1'b0;
                dir_ff[sie_ep] <= 1'b1;
                tog_ff[sie_ep] <= ~tog_ff[sie_ep];
            end else if (sie_error) begin
                err_ff[sie_ep] <= 1'b1;
            end
            if (w_sel && wr_en && !wbyte_ff[BS_RXCLR_N] &&
                !(sie_rx_done && sie_ep == wbyte_ff[EP_W-1:0])) begin
                rxf_ff[wbyte_ff[EP_W-1:0]] <= 1'b0;
            end
            if (w_hs && wr_en) begin
                stall_ff[sel_ep_ff] <= wbyte_ff[HS_STALL];
                tog_ff[sel_ep_ff] <= wbyte_ff[HS_TOGGLE];
            end
            if (w_cnt && wr_en) begin
                tx_cnt_ff[sel_ep_ff] <= wbyte_ff;
                txl_ff[sel_ep_ff] <= 1'b1;
            end
        end
    end

    // The engine write takes priority on a shared byte; software should
    // not touch a region the engine is filling.
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            if (w_data && wr_en) begin
                buf_mem[cpu_addr] <= wbyte_ff;
            end
            if (sie_buf_wr) begin
                buf_mem[sie_buf_addr] <= sie_buf_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sie_rdata_ff <= 8'h00;
            sie_txc_ff <= 8'h00;
        end else if (clk_en) begin
            sie_rdata_ff <= buf_mem[sie_buf_addr];
            sie_txc_ff <= tx_cnt_ff[sie_ep];
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = {24'h000000, rdata_ff};
    assign sie_buf_rdata = sie_rdata_ff;
    assign sie_tx_count = sie_txc_ff;
    assign function_address = func_addr_ff;
    assign endpoint_enable = {ep_en_ff, 1'b1};
    assign endpoint_stall = stall_ff;
    assign endpoint_toggle = tog_ff;
    assign transmit_loaded_flag = txl_ff;
    assign config_device_address = cfg_ff[CF_DEV_LSB+1:CF_DEV_LSB];
    assign config_device1_enable = cfg_ff[CF_DEV1_EN];
    assign config_device2_enable = cfg_ff[CF_DEV2_EN];
    assign buffer_to_device0 = cfg_ff[CF_BUF_DEV0];
    assign clock_stop_request = ctrl_ff[MC_CLK_STOP];
    assign drive_resume = ctrl_ff[MC_RSM_DRV];
    assign suspend_in = ctrl_ff[MC_SUSPEND];
    assign usb_irq = irq_ff;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_sof_set: assert property (
        clk_en && sie_sof && ctrl_ff[MS_SOF] |=> st_sof_ff)
        else $error("frame flag not set");
    a_sof_clear: assert property (
        clk_en && wr_en && w_ctrl && !wbyte_ff[MS_SOF] && !sie_sof
        |=> !st_sof_ff)
        else $error("frame flag not cleared");
    a_idle_clear: assert property (
        clk_en && wr_en && w_ctrl && !wbyte_ff[MS_IDLE] && !sie_bus_idle
        |=> !st_idle_ff)
        else $error("idle flag not cleared");
    a_resume_ctl: assert property (
        clk_en && wr_en && w_ctrl |=>
        drive_resume == $past(wbyte_ff[MC_RSM_DRV]) &&
        suspend_in == $past(wbyte_ff[MC_SUSPEND]))
        else $error("resume or suspend output wrong");
    a_addr_top_zero: assert property (
        rvalid_ff && rd_idx_ff == REG_FUNCTION_ADDRESS |-> !rdata_ff[7])
        else $error("address bit 7 not zero");
    a_ep0_always: assert property (
        rvalid_ff && rd_idx_ff == REG_ENDPOINT_ENABLE |->
        endpoint_enable[0] && rdata_ff[0] && rdata_ff[7:4] == 4'h0)
        else $error("endpoint enable wrong");
    a_rxfull_clear: assert property (
        clk_en && wr_en && w_sel && !wbyte_ff[BS_RXCLR_N] && !sie_rx_done
        |=> !rxf_ff[sel_ep_ff])
        else $error("receive full not cleared");
    a_count_loads: assert property (
        clk_en && wr_en && w_cnt |=> txl_ff[$past(sel_ep_ff)] &&
        tx_cnt_ff[$past(sel_ep_ff)] == $past(wbyte_ff))
        else $error("count write did not load");
    a_stall_write: assert property (
        clk_en && wr_en && w_hs |=>
        stall_ff[$past(sel_ep_ff)] == $past(wbyte_ff[HS_STALL]))
        else $error("stall not written");
    a_ptr_step: assert property (
        clk_en && ar_go && r_data |=> ptr_ff == $past(ptr_ff) + 3'h1)
        else $error("pointer did not advance");
    a_write_answer: assert property (
        wr_go |=> s_axi_bvalid)
        else $error("write response late");

    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_data_read: cover property (rvalid_ff &&
        rd_idx_ff == REG_BUFFER_DATA_PORT);
    c_rx_then_clear: cover property (sie_rx_done ##[1:20] w_sel && wr_en);
endmodule // uuer_regs
`default_nettype wire

// file: uuer_sie_model.sv
/* Stand-in for the serial engine: event pulses and buffer reads.
   Assumes the register block samples every input on clk_sys. */
`timescale 1ns/1ps
`default_nettype none
module uuer_sie_model (
    input wire logic clk_sys,
    output logic sie_sof,
    output logic sie_bus_idle,
    output logic sie_bus_reset,
    output logic sie_resume,
    output logic [1:0] sie_ep,
    output logic sie_rx_done,
    output logic sie_rx_setup,
    output logic [7:0] sie_rx_count,
    output logic sie_tx_done,
    output logic sie_error,
    output logic sie_buf_wr,
    output logic [5:0] sie_buf_addr,
    output logic [7:0] sie_buf_wdata,
    input wire logic [7:0] sie_buf_rdata,
    input wire logic [7:0] sie_tx_count
);
    logic [5:0] p;
    assign {sie_error, sie_tx_done, sie_rx_done} = p[5:3];
    assign {sie_resume, sie_bus_idle, sie_sof} = p[2:0];
    initial begin
        {p, sie_ep, sie_rx_setup, sie_rx_count, sie_bus_reset} = '0;
        {sie_buf_wr, sie_buf_addr, sie_buf_wdata} = '0;
    end
    // Count and setup qualifiers go to their inverse once released; sie_ep keeps its value.
    task automatic ev(input logic [5:0] k, input logic [1:0] e,
                      input logic [7:0] c);
        @(posedge clk_sys);
        p <= k;
        sie_ep <= e;
        sie_rx_count <= c;
        sie_rx_setup <= k[3];
        @(posedge clk_sys);
        p <= '0;
        sie_rx_count <= ~c;
        sie_rx_setup <= ~k[3];
    endtask
    task automatic br(input logic v);
        @(posedge clk_sys);
        sie_bus_reset <= v;
    endtask
    task automatic peek(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sie_buf_addr <= a;
        repeat (2) @(posedge clk_sys);
        d = sie_buf_rdata;
    endtask
endmodule // uuer_sie_model
`default_nettype wire

// file: tb_uuer_regs.sv
/* Self-checking bench for the upstream endpoint register block.
   Assumes the engine stand-in drives all engine-side inputs. */
`timescale 1ns/1ps
`default_nettype none
module tb_uuer_regs;
import uuer_pkg::*;
logic clk_sys, reset, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
logic s_axi_arready, s_axi_rvalid, sie_sof, sie_bus_idle, sie_bus_reset;
logic sie_resume, sie_rx_done, sie_rx_setup, sie_tx_done, sie_error;
logic sie_buf_wr, config_device1_enable, config_device2_enable, usb_irq;
logic buffer_to_device0, clock_stop_request, drive_resume, suspend_in;
logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb, endpoint_enable, endpoint_stall, endpoint_toggle;
logic [3:0] transmit_loaded_flag;
logic [1:0] s_axi_bresp, s_axi_rresp, sie_ep, config_device_address, rsp;
logic [7:0] sie_rx_count, sie_buf_wdata, sie_buf_rdata, sie_tx_count, rd;
logic [6:0] function_address;
logic [BUF_AW-1:0] sie_buf_addr;
int n_mismatch, checked;
wire [7:0] ctl_pins = {suspend_in, drive_resume, 1'b0, clock_stop_request,
                       4'h0};
wire [7:0] cfg_pins = {3'h0, buffer_to_device0, config_device2_enable,
                       config_device1_enable, config_device_address};
uuer_regs i_uuer_regs (.*);
uuer_sie_model i_uuer_sie_model (.*);
initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
end
task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
        n_mismatch++;
        $display("[ERR] %s exp %h got %h", n, e, g);
    end
endtask
// Each bus wait is bounded; running out of it ends the run.
task automatic hang;
    ck("bus_wait", 8'h01, 8'h00);
    complete_run;
endtask
task automatic wr(input logic [WORD_W-1:0] i, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 99 && !s_axi_bvalid; n++) begin
        @(posedge clk_sys);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n == 99) hang;
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
endtask
task automatic rdr(input logic [WORD_W-1:0] i);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= {i, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 99 && !s_axi_rvalid; n++) begin
        @(posedge clk_sys);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n == 99) hang;
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
endtask
task automatic t_regs;
    rdr(REG_MAIN_CONTROL);
    ck("ctl_rst", 8'h00, rd);
    wr(REG_MAIN_CONTROL, 8'hd0);
    ck("ctl", 8'hd0, ctl_pins);
    wr(REG_FUNCTION_ADDRESS, 8'hff);
    rdr(REG_FUNCTION_ADDRESS);
    ck("fa", 8'h7f, rd);
    ck("fa_pin", 8'h7f, {1'b0, function_address});
    s_axi_wstrb <= 4'h0;
    wr(REG_FUNCTION_ADDRESS, 8'h00);
    s_axi_wstrb <= 4'hf;
    ck("fa_ok", 8'h00, {6'h0, rsp});
    ck("fa_strb", 8'h7f, {1'b0, function_address});
    wr(REG_ENDPOINT_ENABLE, 8'h00);
    ck("epe0", 8'h01, {4'h0, endpoint_enable});
    wr(REG_ENDPOINT_ENABLE, 8'hff);
    rdr(REG_ENDPOINT_ENABLE);
    ck("epe", 8'h0f, {rd[7:4], endpoint_enable});
    wr(REG_ENDPOINT_CONFIG, 8'hff);
    ck("cfg", 8'h1f, cfg_pins);
    rdr(REG_ENDPOINT_CONFIG);
    ck("cfg_rd", 8'h00, rd);
    wr(REG_ENDPOINT_CONFIG, 8'h33);
    ck("cfg1", 8'h0f, cfg_pins);
    wr(10'h001, 8'h00);
    ck("bad", {6'h0, RESP_SLVERR}, {6'h0, rsp});
    rdr(10'h001);
    ck("bad_rd", {6'h0, RESP_SLVERR}, {6'h0, rsp});
    ck("bad_rdata", 8'h00, rd);
    $display("done regs");
endtask
task automatic t_evt;
    wr(REG_MAIN_CONTROL, 8'h2f);
    i_uuer_sie_model.ev(6'h07, 2'h0, 8'h00);
    i_uuer_sie_model.br(1'b1);
    rdr(REG_MAIN_STATUS);
    ck("sts", 8'h99, rd);
    ck("irq", 8'h01, {7'h0, usb_irq});
    wr(REG_MAIN_CONTROL, 8'h00);
    i_uuer_sie_model.ev(6'h07, 2'h0, 8'h00);
    rdr(REG_MAIN_STATUS);
    ck("sts_clr", 8'h18, rd);
    wr(REG_MAIN_CONTROL, 8'h00);
    i_uuer_sie_model.br(1'b0);
    rdr(REG_MAIN_STATUS);
    ck("idle_clr", 8'h00, rd);
    clk_en <= 1'b0;
    i_uuer_sie_model.ev(6'h02, 2'h0, 8'h00);
    clk_en <= 1'b1;
    rdr(REG_MAIN_STATUS);
    ck("frozen", 8'h00, rd);
    $display("done events");
endtask
task automatic t_rx;
    wr(REG_MAIN_CONTROL, 8'h02);
    i_uuer_sie_model.ev(6'h08, 2'h1, 8'h2a);
    rdr(REG_MAIN_STATUS);
    ck("rxf", 8'h02, rd);
    wr(REG_BUFFER_SELECT, 8'h09);
    rdr(REG_BUFFER_COUNT_LOW);
    ck("rxcnt", 8'h2a, rd);
    rdr(REG_HANDSHAKE_STATUS);
    ck("hs_rx", 8'h3c, rd & 8'hbe);
    wr(REG_BUFFER_SELECT, 8'h01);
    rdr(REG_HANDSHAKE_STATUS);
    ck("rx_clr", 8'h00, rd & 8'h20);
    $display("done rx");
endtask
task automatic t_tx;
    int i;
    wr(REG_BUFFER_SELECT, 8'h05);
    for (i = 0; i < 3; i++) wr(REG_BUFFER_DATA_PORT, 8'(8'h11 * (i + 1)));
    i_uuer_sie_model.peek(6'h19, rd);
    ck("sie_rd", 8'h22, rd);
    wr(REG_BUFFER_SELECT, 8'h05);
    for (i = 0; i < 3; i++) begin
        rdr(REG_BUFFER_DATA_PORT);
        ck("data", 8'(8'h11 * (i + 1)), rd);
    end
    rdr(REG_BUFFER_SELECT);
    ck("sel", 8'h01, rd & 8'hf3);
    wr(REG_MAIN_CONTROL, 8'h04);
    wr(REG_BUFFER_COUNT_LOW, 8'h10);
    ck("loaded", 8'h02, {4'h0, transmit_loaded_flag});
    i_uuer_sie_model.ev(6'h10, 2'h1, 8'h00);
    ck("txcnt", 8'h10, sie_tx_count);
    rdr(REG_HANDSHAKE_STATUS);
    ck("hs_tx", 8'h81, rd & 8'h93);
    rdr(REG_MAIN_STATUS);
    ck("txe", 8'h04, rd & 8'h04);
    wr(REG_PROCESSOR_COUNT_LOW, 8'h20);
    ck("loaded_ae", 8'h02, {4'h0, transmit_loaded_flag});
    rdr(REG_PROCESSOR_COUNT_LOW);
    ck("rxcnt_ae", 8'h2a, rd);
    i_uuer_sie_model.ev(6'h20, 2'h1, 8'h00);
    ck("txcnt_ae", 8'h20, sie_tx_count);
    wr(REG_HANDSHAKE_STATUS, 8'h14);
    rdr(REG_HANDSHAKE_STATUS);
    ck("err", 8'h12, rd & 8'h12);
    ck("stall", 8'h22, {endpoint_stall, endpoint_toggle});
    $display("done tx");
endtask
initial begin
    {reset, clk_en, s_axi_wstrb} = 6'h3f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs;
    t_evt;
    t_rx;
    t_tx;
    complete_run;
end
endmodule // tb_uuer_regs
`default_nettype wire
